// ---- hdl/cms_pkg.sv ----
package cms_pkg;

  typedef enum logic [3:0] {
    CMS_SHUTDOWN = 4'h1,
    CMS_STANDBY  = 4'h2,
    CMS_ACQUIRE  = 4'h4,
    CMS_TRANSMIT = 4'h8
  } cms_state_t;

endpackage

// ---- hdl/cms_regs.svh ----
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH

// Sampling clock rate and the pixel clock activity thresholds.
`define CMS_CLK_HZ         25000000
`define CMS_STANDBY_HZ     500000
`define CMS_ACTIVE_HZ      3000000
`define CMS_IDLE_CYCLES    (`CMS_CLK_HZ / `CMS_STANDBY_HZ)
`define CMS_ACTIVE_CYCLES  (`CMS_CLK_HZ / `CMS_ACTIVE_HZ)

// Serializer shape and default wait times in clock cycles.
`define CMS_BITS_PER_WORD  8
`define CMS_FIFO_DEPTH     8
`define CMS_LOCK_CYCLES    64
`define CMS_PWRDN_CYCLES   16

`endif

// ---- hdl/cms_sequencer.sv ----
`timescale 1ns/1ps
`include "cms_regs.svh"

module cms_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             flush,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset || flush)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module cms_sequencer #(
  parameter int LOCK_CYCLES  = `CMS_LOCK_CYCLES,
  parameter int PWRDN_CYCLES = `CMS_PWRDN_CYCLES,
  parameter int FIFO_DEPTH   = `CMS_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       reset,
  // Control pins.
  input  wire logic       transmitter_enable_pin,
  input  wire logic       mode_pin,
  // Camera side.
  input  wire logic       pixel_clock_in,
  input  wire logic       frame_sync_in,
  input  wire logic       line_sync_in,
  input  wire logic [7:0] pixel_data_in,
  // Serial lanes.
  output logic            serial_clk_p_out,
  output logic            serial_clk_n_out,
  output logic            serial_clk_oe,
  output logic            serial_data_out,
  output logic            serial_data_oe,
  // Status.
  output logic            pll_enable,
  output logic            monitor_enable,
  output logic     [15:0] frame_lines,
  output logic            pixel_overflow
);
  localparam logic [7:0] IDLE_CYC   = 8'(`CMS_IDLE_CYCLES);
  localparam logic [7:0] ACTIVE_CYC = 8'(`CMS_ACTIVE_CYCLES);
  localparam logic [15:0] LOCK_C    = 16'(LOCK_CYCLES);
  localparam logic [15:0] PWRDN_C   = 16'(PWRDN_CYCLES);

  cms_pkg::cms_state_t state_q;
  cms_pkg::cms_state_t state_d;
  logic [12:0] meta_q;
  logic [12:0] sync_q;
  logic        pclk_prev_q;
  logic        fs_prev_q;
  logic        ls_prev_q;
  logic        s_en;
  logic        s_mode;
  logic        s_pclk;
  logic        s_fs;
  logic        s_ls;
  logic [7:0]  s_data;
  logic        pclk_rise;
  logic        fs_rise;
  logic        fs_fall;
  logic        ls_rise;
  logic [7:0]  gap_q;
  logic [7:0]  period_q;
  logic        clk_missing;
  logic        clk_fast;
  logic [15:0] en_low_q;
  logic        shutdown_req;
  logic [15:0] lock_q;
  logic        locked;
  logic [1:0]  fs_cnt_q;
  logic [1:0]  fs_need;
  logic [15:0] lines_q;
  logic        capture_on;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [7:0]  fifo_out_data;
  logic [7:0]  bit_div;
  logic [7:0]  bit_cnt_q;
  logic        bit_en;
  logic        shift_en;
  logic [7:0]  sh_q;
  logic [3:0]  left_q;

  // Input pins pass two flip-flops before use.
  always_ff @(posedge clock)
  begin
    meta_q <= {transmitter_enable_pin, mode_pin, pixel_clock_in, frame_sync_in,
               line_sync_in, pixel_data_in};
    sync_q <= meta_q;
    {pclk_prev_q, fs_prev_q, ls_prev_q} <= {s_pclk, s_fs, s_ls};
  end

  assign {s_en, s_mode, s_pclk, s_fs, s_ls, s_data} = sync_q;
  assign pclk_rise = s_pclk && !pclk_prev_q;
  assign fs_rise   = s_fs && !fs_prev_q;
  assign fs_fall   = !s_fs && fs_prev_q;
  assign ls_rise   = s_ls && !ls_prev_q;

  // Pixel clock activity monitor measures the period between rising edges.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      gap_q    <= 8'hFF;
      period_q <= 8'hFF;
    end
    else if (pclk_rise)
    begin
      gap_q    <= 8'h00;
      period_q <= (gap_q == 8'hFF) ? 8'hFF : gap_q + 8'h01;
    end
    else if (gap_q != 8'hFF)
    begin
      gap_q <= gap_q + 8'h01;
    end
  end

  assign clk_missing = (gap_q >= IDLE_CYC);
  assign clk_fast    = !clk_missing && (period_q <= ACTIVE_CYC);

  // Enable must stay low for the power-down time before shutdown is taken.
  always_ff @(posedge clock)
  begin
    if (reset || s_en)
    begin
      en_low_q <= 16'h0000;
    end
    else if (en_low_q != PWRDN_C)
    begin
      en_low_q <= en_low_q + 16'h0001;
    end
  end

  assign shutdown_req = !s_en && (en_low_q == PWRDN_C);
  assign locked       = (lock_q == LOCK_C);
  assign fs_need      = s_mode ? 2'h2 : 2'h1;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      cms_pkg::CMS_SHUTDOWN: if (s_en) state_d = cms_pkg::CMS_STANDBY;
      cms_pkg::CMS_STANDBY:  if (shutdown_req) state_d = cms_pkg::CMS_SHUTDOWN;
                             else if (clk_fast) state_d = cms_pkg::CMS_ACQUIRE;
      cms_pkg::CMS_ACQUIRE:  if (shutdown_req) state_d = cms_pkg::CMS_SHUTDOWN;
                             else if (clk_missing) state_d = cms_pkg::CMS_STANDBY;
                             else if (locked && fs_cnt_q == fs_need)
                               state_d = cms_pkg::CMS_TRANSMIT;
      cms_pkg::CMS_TRANSMIT: if (shutdown_req) state_d = cms_pkg::CMS_SHUTDOWN;
                             else if (clk_missing) state_d = cms_pkg::CMS_STANDBY;
      default:               state_d = cms_pkg::CMS_SHUTDOWN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= cms_pkg::CMS_SHUTDOWN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Lock wait runs only in acquire and counts frame starts once locked.
  always_ff @(posedge clock)
  begin
    if (reset || state_q != cms_pkg::CMS_ACQUIRE)
    begin
      lock_q   <= 16'h0000;
      fs_cnt_q <= 2'h0;
    end
    else
    begin
      if (!locked)
      begin
        lock_q <= lock_q + 16'h0001;
      end
      else if (fs_rise && fs_cnt_q != fs_need)
      begin
        fs_cnt_q <= fs_cnt_q + 2'h1;
      end
    end
  end

  // Power control: PLL only while active, monitor whenever enabled.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pll_enable     <= 1'b0;
      monitor_enable <= 1'b0;
    end
    else
    begin
      pll_enable     <= state_d == cms_pkg::CMS_ACQUIRE || state_d == cms_pkg::CMS_TRANSMIT;
      monitor_enable <= state_d != cms_pkg::CMS_SHUTDOWN;
    end
  end

  // Line counter restarts on each frame start and its total is kept at frame end.
  always_ff @(posedge clock)
  begin
    if (reset || !pll_enable)
    begin
      lines_q     <= 16'h0000;
      frame_lines <= 16'h0000;
    end
    else if (fs_rise)
    begin
      lines_q <= {15'h0000, ls_rise};
    end
    else if (fs_fall)
    begin
      frame_lines <= lines_q;
      lines_q     <= 16'h0000;
    end
    else if (s_fs && ls_rise)
    begin
      lines_q <= lines_q + 16'h0001;
    end
  end

  // One word per pixel clock rise is captured once the PLL is locked.
  assign capture_on = (state_q == cms_pkg::CMS_ACQUIRE && locked) ||
                      state_q == cms_pkg::CMS_TRANSMIT;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pixel_overflow <= 1'b0;
    end
    else
    begin
      pixel_overflow <= capture_on && pclk_rise && !fifo_in_ready;
    end
  end

  cms_fifo #(
    .WIDTH (`CMS_BITS_PER_WORD),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .flush     (!capture_on),
    .in_valid  (capture_on && pclk_rise),
    .in_ready  (fifo_in_ready),
    .in_data   (s_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Output enables: clock leads data both on the way up and on the way down.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      serial_clk_oe  <= 1'b0;
      serial_data_oe <= 1'b0;
    end
    else
    begin
      serial_clk_oe  <= state_q == cms_pkg::CMS_TRANSMIT;
      serial_data_oe <= serial_clk_oe;
    end
  end

  // Bit enable divides the measured pixel period by eight.
  assign bit_div = (period_q[7:3] == 5'h00) ? 8'h01 : {3'h0, period_q[7:3]};
  assign bit_en  = serial_clk_oe && (bit_cnt_q == bit_div - 8'h01);
  assign shift_en = bit_en && serial_data_oe;
  assign fifo_out_ready = shift_en && left_q == 4'h0;

  always_ff @(posedge clock)
  begin
    if (reset || !serial_clk_oe || bit_en)
    begin
      bit_cnt_q <= 8'h00;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 8'h01;
    end
  end

  // Serial clock gives one pulse per bit; the two legs are complementary.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      serial_clk_p_out <= 1'b0;
      serial_clk_n_out <= 1'b1;
    end
    else
    begin
      serial_clk_p_out <= bit_en;
      serial_clk_n_out <= !bit_en;
    end
  end

  // Shift register sends each word low bit first, zeros when starved.
  always_ff @(posedge clock)
  begin
    if (reset || !serial_data_oe)
    begin
      sh_q            <= 8'h00;
      left_q          <= 4'h0;
      serial_data_out <= 1'b0;
    end
    else if (shift_en)
    begin
      if (left_q != 4'h0)
      begin
        serial_data_out <= sh_q[0];
        sh_q            <= sh_q >> 1;
        left_q          <= left_q - 4'h1;
      end
      else if (fifo_out_valid)
      begin
        serial_data_out <= fifo_out_data[0];
        sh_q            <= fifo_out_data >> 1;
        left_q          <= 4'(`CMS_BITS_PER_WORD - 1);
      end
      else
      begin
        serial_data_out <= 1'b0;
      end
    end
  end

  a_shutdown_hiz: assert property (@(posedge clock) disable iff (reset)
    (state_q == cms_pkg::CMS_SHUTDOWN) |=> !serial_clk_oe ##1 !serial_data_oe)
    else $error("Outputs enabled in shutdown.");
  a_standby_pll: assert property (@(posedge clock) disable iff (reset)
    (state_q == cms_pkg::CMS_STANDBY) |-> !pll_enable && monitor_enable ##1 !serial_clk_oe)
    else $error("Standby power state wrong.");
  a_acquire_entry: assert property (@(posedge clock) disable iff (reset)
    (state_q == cms_pkg::CMS_STANDBY && clk_fast && !shutdown_req)
      |=> state_q == cms_pkg::CMS_ACQUIRE)
    else $error("Acquire not entered on active clock.");
  a_frame_starts: assert property (@(posedge clock) disable iff (reset)
    $rose(state_q == cms_pkg::CMS_TRANSMIT) |-> $past(fs_cnt_q) == ($past(s_mode) ? 2'h2 : 2'h1))
    else $error("Transmit entered on wrong frame count.");
  a_lock_first: assert property (@(posedge clock) disable iff (reset)
    $rose(serial_clk_oe) |-> $past(lock_q, 2) == LOCK_C)
    else $error("Output enabled before lock wait.");
  a_clock_first: assert property (@(posedge clock) disable iff (reset)
    $rose(serial_data_oe) |-> $past(serial_clk_oe))
    else $error("Data enabled before clock.");
  a_clock_off_first: assert property (@(posedge clock) disable iff (reset)
    $fell(serial_clk_oe) |-> serial_data_oe ##1 !serial_data_oe)
    else $error("Data released before clock.");
  a_missing_clock: assert property (@(posedge clock) disable iff (reset)
    (state_q == cms_pkg::CMS_TRANSMIT && clk_missing && !shutdown_req)
      |=> state_q == cms_pkg::CMS_STANDBY ##1 !serial_clk_oe ##1 !serial_data_oe)
    else $error("Missing clock did not drop to standby.");
  a_pwrdn_time: assert property (@(posedge clock) disable iff (reset)
    (state_q != cms_pkg::CMS_SHUTDOWN && $past(state_q) != cms_pkg::CMS_SHUTDOWN &&
     state_d == cms_pkg::CMS_SHUTDOWN) |-> en_low_q == PWRDN_C && !s_en)
    else $error("Shutdown without power-down time.");
endmodule

// ---- sim/cms_receiver.sv ----
`timescale 1ns/1ps

module cms_receiver (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // Serial lanes.
  input  wire logic        clk_p,
  input  wire logic        clk_oe,
  input  wire logic        data,
  input  wire logic        data_oe,
  // Collected data.
  output logic       [7:0] last_byte,
  output logic      [15:0] bit_count
);
  logic [7:0] shift_q;
  logic [2:0] idx_q;
  logic       oe_seen_q;

  // Bits are taken only while both lanes are driven, LSB first.
  // The pulse seen as the data lane turns on was launched while it was still released.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      shift_q   <= 8'h00;
      idx_q     <= 3'h0;
      last_byte <= 8'h00;
      bit_count <= 16'h0000;
      oe_seen_q <= 1'b0;
    end
    else if (!data_oe)
    begin
      idx_q     <= 3'h0;
      oe_seen_q <= 1'b0;
    end
    else if (!oe_seen_q)
    begin
      oe_seen_q <= 1'b1;
    end
    else if (clk_p && clk_oe)
    begin
      shift_q   <= {data, shift_q[7:1]};
      idx_q     <= idx_q + 3'h1;
      bit_count <= bit_count + 16'h0001;
      if (idx_q == 3'h7)
        last_byte <= {data, shift_q[7:1]};
    end
  end
endmodule

// ---- sim/cms_sequencer_bench.sv ----
`timescale 1ns/1ps

module cms_sequencer_bench;
  logic        clock;
  logic        reset;
  logic        en;
  logic        mode;
  logic        pclk;
  logic        run;
  logic        fs;
  logic        ls;
  logic  [7:0] pix;
  logic        clk_p;
  logic        clk_n;
  logic        ovf;
  logic        clk_oe;
  logic        dat;
  logic        dat_oe;
  logic        pll;
  logic        mon;
  logic [15:0] lines;
  logic  [7:0] rx_byte;
  logic [15:0] rx_bits;
  logic [15:0] b0;
  int          error_cnt;
  int          compares;
  int          cyc;

  cms_sequencer #(.LOCK_CYCLES(4), .PWRDN_CYCLES(4), .FIFO_DEPTH(8)) dut (
    .clock(clock), .reset(reset), .transmitter_enable_pin(en), .mode_pin(mode),
    .pixel_clock_in(pclk), .frame_sync_in(fs), .line_sync_in(ls), .pixel_data_in(pix),
    .serial_clk_p_out(clk_p), .serial_clk_n_out(clk_n), .serial_clk_oe(clk_oe),
    .serial_data_out(dat), .serial_data_oe(dat_oe), .pll_enable(pll),
    .monitor_enable(mon), .frame_lines(lines), .pixel_overflow(ovf)
  );

  cms_receiver rx (
    .clock(clock), .reset(reset), .clk_p(clk_p), .clk_oe(clk_oe), .data(dat),
    .data_oe(dat_oe), .last_byte(rx_byte), .bit_count(rx_bits)
  );

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // The pixel clock runs at 320 ns only while enabled, changing just after a clock edge.
  initial
  begin
    pclk = 1'b0;
    #21;
    forever
    begin
      #160;
      pclk = run ? ~pclk : 1'b0;
    end
  end

  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares = compares + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic wait_for(ref logic s, input logic v, input int n, input string what);
    int i;
    i = 0;
    while (s !== v && i < n)
    begin
      tick(1);
      i++;
    end
    chk({15'h0000, s}, {15'h0000, v}, what);
  endtask

  task automatic frame(input int n);
    fs = 1'b1;
    tick(4);
    repeat (n)
    begin
      ls = 1'b1;
      tick(6);
      ls = 1'b0;
      tick(6);
    end
    fs = 1'b0;
    tick(8);
  endtask

  task automatic t_reset_standby();
    chk({10'h000, clk_oe, dat_oe, pll, mon, clk_p, clk_n}, 16'h0001, "reset outputs");
    en = 1'b1;
    tick(8);
    chk({12'h000, clk_oe, dat_oe, pll, mon}, 16'h0001, "standby");
  endtask

  task automatic t_mode0_transmit();
    run = 1'b1;
    wait_for(pll, 1'b1, 60, "acquire");
    tick(20);
    chk({15'h0000, clk_oe}, 16'h0000, "no frame yet");
    fs = 1'b1;
    wait_for(clk_oe, 1'b1, 20, "clock lane on");
    chk({15'h0000, dat_oe}, 16'h0000, "data after clock");
    tick(1);
    chk({15'h0000, dat_oe}, 16'h0001, "data lane on");
    fs = 1'b0;
    tick(10);
    frame(5);
    chk(lines, 16'h0005, "frame lines");
    chk({8'h00, rx_byte}, 16'h00A5, "serial word");
    b0 = rx_bits;
    tick(64);
    chk(rx_bits - b0, 16'h0040, "bit rate");
    chk({14'h0000, clk_n, ovf}, {14'h0000, !clk_p, 1'b0}, "clock legs");
  endtask

  task automatic t_clock_loss();
    run = 1'b0;
    wait_for(clk_oe, 1'b0, 90, "clock lane off");
    tick(1);
    chk({15'h0000, dat_oe}, 16'h0000, "data lane off");
    tick(1);
    chk({14'h0000, pll, mon}, 16'h0001, "pll down");
  endtask

  task automatic t_mode1();
    mode = 1'b1;
    tick(4);
    run = 1'b1;
    wait_for(pll, 1'b1, 60, "reacquire");
    tick(10);
    frame(2);
    tick(20);
    chk({15'h0000, clk_oe}, 16'h0000, "one frame only");
    fs = 1'b1;
    wait_for(clk_oe, 1'b1, 20, "second frame");
    fs = 1'b0;
  endtask

  task automatic t_shutdown();
    tick(20);
    en = 1'b0;
    tick(2);
    en = 1'b1;
    tick(12);
    chk({14'h0000, clk_oe, dat_oe}, 16'h0003, "short low ignored");
    en = 1'b0;
    wait_for(clk_oe, 1'b0, 30, "clock legs off");
    chk({15'h0000, dat_oe}, 16'h0001, "data still on");
    tick(1);
    chk({15'h0000, dat_oe}, 16'h0000, "data off");
    tick(2);
    chk({14'h0000, pll, mon}, 16'h0000, "shutdown");
  endtask

  task automatic report_and_stop();
    $display("Errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    error_cnt = 0;
    compares = 0;
    cyc = 0;
    reset = 1'b1;
    en = 1'b0;
    mode = 1'b0;
    run = 1'b0;
    fs = 1'b0;
    ls = 1'b0;
    pix = 8'hA5;
    tick(10);
    reset = 1'b0;
    tick(1);
    t_reset_standby();
    t_mode0_transmit();
    t_clock_loss();
    t_mode1();
    t_shutdown();
    report_and_stop();
  end
endmodule
